// ### bench/host_model.sv
// host_model: stand-in for the host side serial engine, turning select and
// register writes into one-cycle command strobes for the bank.
// assumes: sys_clk is the bank clock; commands change at its falling edge.
`timescale 1ns/1ns
module host_model (
	input  wire logic                      sys_clk,
	output thermal_regs_pkg::host_cmd_type host_cmd
);
	import thermal_regs_pkg::*;

	initial host_cmd = '0;

	////////////////////////////////////////////////////////////////////////
	task automatic set_select(input logic [7:0] sel);
		@(negedge sys_clk);
		host_cmd.select_wr   = 1'b1;
		host_cmd.select_byte = sel;
		@(negedge sys_clk);
		host_cmd.select_wr   = 1'b0;
		// stale byte is inverted so nothing can lean on it
		host_cmd.select_byte = ~sel;
	endtask

	// only the eight assigned selects exist, so no reserved target is hit
	task automatic write_reg(input logic [15:0] data);
		@(negedge sys_clk);
		host_cmd.reg_wr    = 1'b1;
		host_cmd.reg_wdata = data;
		@(negedge sys_clk);
		host_cmd.reg_wr    = 1'b0;
		host_cmd.reg_wdata = ~data;
	endtask
endmodule // host_model

// ### bench/tb_thermal_sensor_register_bank.sv
// tb_thermal_sensor_register_bank: self-checking bench of the register bank.
// assumes: host_model issues commands; bench drives inputs at falling edges.
`timescale 1ns/1ns
module tb_thermal_sensor_register_bank;
	import thermal_regs_pkg::*;
	localparam logic [15:0] MAKER_ID = 16'h1234; // arbitrary value
	localparam logic [15:0] PART_ID  = 16'h4321; // arbitrary value
	localparam int          LIMIT    = 20000;

	logic             sys_clk       = 1'b0;
	logic             rst           = 1'b1;
	host_cmd_type     host_cmd;
	logic [15:0]      reading_in    = 16'h0c35;
	logic             sample_strobe = 1'b0;
	logic             alarm_hit     = 1'b0;
	logic             critical_hit  = 1'b0;
	logic [15:0]      rd_data;
	logic [15:0]      high_limit;
	logic [15:0]      low_limit;
	logic [15:0]      crit_limit;
	logic [7:0]       register_select;
	setup_fields_type setup_fields;
	logic [3:0]       reading_bits;
	logic [3:0]       reading_step;
	logic             event_pin_out;
	logic             event_pin_oe;
	int               n_errors      = 0;
	int               checked       = 0;
	int               cycles        = 0;

	always #5 sys_clk = ~sys_clk;

	host_model u_host_model (.sys_clk(sys_clk), .host_cmd(host_cmd));

	thermal_sensor_register_bank #(.MAKER_ID_VALUE(MAKER_ID), .PART_ID_VALUE(PART_ID))
	u_thermal_sensor_register_bank (
		.sys_clk(sys_clk), .rst(rst), .host_cmd(host_cmd), .reading_in(reading_in),
		.sample_strobe(sample_strobe), .alarm_hit(alarm_hit), .critical_hit(critical_hit),
		.rd_data(rd_data), .register_select(register_select), .setup_fields(setup_fields),
		.high_limit(high_limit), .low_limit(low_limit), .crit_limit(crit_limit),
		.reading_bits(reading_bits), .reading_step(reading_step),
		.event_pin_out(event_pin_out), .event_pin_oe(event_pin_oe));

	////////////////////////////////////////////////////////////////////////
	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_bit(input string what, input logic exp, input logic got);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %s expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic read_reg(input logic [7:0] sel, input logic [15:0] exp);
		u_host_model.set_select(sel);
		repeat (2) @(negedge sys_clk);
		chk_word("rd_data", exp, rd_data);
	endtask

	task automatic write_at(input logic [7:0] sel, input logic [15:0] data);
		u_host_model.set_select(sel);
		u_host_model.write_reg(data);
	endtask

	task automatic sample(input logic alarm, input logic crit);
		@(negedge sys_clk);
		alarm_hit     = alarm;
		critical_hit  = crit;
		sample_strobe = 1'b1;
		@(negedge sys_clk);
		sample_strobe = 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic test_reset_state;
		chk_word("register_select", 16'h0000, {8'h00, register_select});
		chk_word("rd_data", 16'h000f, rd_data);
		chk_word("setup_fields", 16'h0000, {7'h00, setup_fields});
		chk_word("crit_limit", 16'h0000, crit_limit);
		chk_bit("event_pin_oe", 1'b0, event_pin_oe);
		chk_bit("event_pin_out", 1'b0, event_pin_out);
		chk_word("reading_bits", 16'h000a, {12'h000, reading_bits});
		chk_word("reading_step", 16'h0004, {12'h000, reading_step});
		chk_bit("cap bit 0", 1'b1, rd_data[0]);
		chk_bit("cap bit 1", 1'b1, rd_data[1]);
		chk_bit("cap bit 2", 1'b1, rd_data[2]);
		chk_word("cap bits 4:3", 16'h0001, {14'h0000, rd_data[4:3]});
		chk_bit("cap bit 5", 1'b0, rd_data[5]);
		chk_bit("cap bit 6", 1'b0, rd_data[6]);
		chk_bit("cap bit 7", 1'b0, rd_data[7]);
		chk_word("cap bits 15:8", 16'h0000, {8'h00, rd_data[15:8]});
	endtask

	task automatic test_map;
		write_at(8'h02, 16'h0190);
		write_at(8'h03, 16'h0050);
		write_at(8'h04, 16'h01e0);
		chk_word("low_limit", 16'h0050, low_limit);
		read_reg(8'h00, 16'h000f);
		read_reg(8'h01, 16'h0000);
		read_reg(8'h02, 16'h0190);
		read_reg(8'h03, 16'h0050);
		read_reg(8'h04, 16'h01e0);
		read_reg(8'h05, reading_in);
		read_reg(8'h06, MAKER_ID);
		read_reg(8'h07, PART_ID);
		chk_word("high_limit", 16'h0190, high_limit);
	endtask

	task automatic ro_probe(input logic [7:0] sel, input logic [15:0] exp);
		write_at(sel, 16'hffff);
		read_reg(sel, exp);
		chk_word("register_select", {8'h00, sel}, {8'h00, register_select});
	endtask

	task automatic test_select_and_ro;
		read_reg(8'hfd, reading_in);
		chk_word("register_select", 16'h0005, {8'h00, register_select});
		ro_probe(8'h00, 16'h000f);
		ro_probe(8'h05, reading_in);
		ro_probe(8'h06, MAKER_ID);
		ro_probe(8'h07, PART_ID);
	endtask

	task automatic test_hysteresis;
		for (int i = 0; i < 4; i++) begin
			write_at(8'h01, {5'h00, i[1:0], 9'h000});
			chk_word("hysteresis", {14'h0000, i[1:0]}, {14'h0000, setup_fields.hysteresis});
			read_reg(8'h01, {5'h00, i[1:0], 9'h000});
		end
	endtask

	task automatic test_event;
		// comparator: status follows each sample, clear bit has no effect
		write_at(8'h01, 16'h0008);
		sample(1'b0, 1'b1);
		chk_bit("event_pin_oe", 1'b1, event_pin_oe);
		read_reg(8'h01, 16'h0018);
		u_host_model.write_reg(16'h0028);
		read_reg(8'h01, 16'h0018);
		sample(1'b0, 1'b0);
		read_reg(8'h01, 16'h0008);
		// interrupt: status sticks until cleared by bit 5
		write_at(8'h01, 16'h0009);
		sample(1'b1, 1'b0);
		sample(1'b0, 1'b0);
		read_reg(8'h01, 16'h0019);
		u_host_model.write_reg(16'h0029);
		read_reg(8'h01, 16'h0009);
		chk_bit("event_pin_oe", 1'b0, event_pin_oe);
	endtask

	task automatic test_modes;
		// comparator, critical only, active-high pin
		write_at(8'h01, 16'h000e);
		read_reg(8'h01, 16'h000e);
		chk_bit("event_pin_oe", 1'b1, event_pin_oe);
		sample(1'b1, 1'b0);
		read_reg(8'h01, 16'h000e);
		sample(1'b0, 1'b1);
		chk_bit("event_pin_oe", 1'b0, event_pin_oe);
		// shutdown freezes status and pin until a sample after exit
		u_host_model.write_reg(16'h010e);
		sample(1'b0, 1'b0);
		read_reg(8'h01, 16'h011e);
		chk_bit("event_pin_oe", 1'b0, event_pin_oe);
		u_host_model.write_reg(16'h000e);
		read_reg(8'h01, 16'h001e);
		sample(1'b0, 1'b0);
		read_reg(8'h01, 16'h000e);
		chk_bit("event_pin_oe", 1'b1, event_pin_oe);
	endtask

	task automatic test_locks;
		write_at(8'h02, 16'h0123);
		write_at(8'h01, 16'h00c0);
		read_reg(8'h01, 16'h00c0);
		write_at(8'h02, 16'h0456);
		read_reg(8'h02, 16'h0123);
		write_at(8'h04, 16'h0777);
		read_reg(8'h04, 16'h01e0);
		write_at(8'h01, 16'h0100);
		read_reg(8'h01, 16'h00c0);
		@(negedge sys_clk);
		rst = 1'b1;
		repeat (3) @(negedge sys_clk);
		rst = 1'b0;
		chk_word("setup_fields", 16'h0000, {7'h00, setup_fields});
		chk_word("high_limit", 16'h0000, high_limit);
		chk_word("rd_data", 16'h000f, rd_data);
		write_at(8'h02, 16'h0456);
		read_reg(8'h02, 16'h0456);
	endtask

	////////////////////////////////////////////////////////////////////////
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			n_errors++;
			end_sim();
		end
	end

	initial begin
		repeat (16) @(posedge sys_clk);
		@(negedge sys_clk);
		rst = 1'b0;
		test_reset_state();
		test_map();
		test_select_and_ro();
		test_hysteresis();
		test_event();
		test_modes();
		test_locks();
		end_sim();
	end
endmodule // tb_thermal_sensor_register_bank

// ### core/resolution_decoder.sv
// resolution_decoder: turns a two-bit resolution code into reading width and
// step size.
// assumes: code is static or registered upstream; output is combinational.
`timescale 1ns/1ns
module resolution_decoder (
	input  wire logic [1:0] res_code,
	output logic      [3:0] res_bits,
	output logic      [3:0] res_step
);
	import thermal_regs_pkg::*;

	always_comb begin
		case (res_code)
			2'b00: begin
				res_bits = RES_BITS_HALF;
				res_step = RES_STEP_HALF;
			end
			2'b01: begin
				res_bits = RES_BITS_QUARTER;
				res_step = RES_STEP_QUARTER;
			end
			2'b10: begin
				res_bits = RES_BITS_EIGHTH;
				res_step = RES_STEP_EIGHTH;
			end
			default: begin
				res_bits = RES_BITS_SIXTEENTH;
				res_step = RES_STEP_SIXTEENTH;
			end
		endcase
	end

endmodule // resolution_decoder

// ### core/thermal_regs_pkg.sv
// thermal_regs_pkg: register map, field layout, reset values and carrier types
// of the thermal sensor register bank.
// assumes: used by the bank, its resolution decoder, host_model and the bench.
package thermal_regs_pkg;

	localparam int SELECT_WIDTH = 8;
	localparam int SELECT_USED  = 3;
	localparam int DATA_WIDTH   = 16;

	// register selects: 3-bit binary codes
	typedef enum logic [2:0] {
		SEL_CAPABILITY = 3'b000,
		SEL_SETUP      = 3'b001,
		SEL_HIGH_LIMIT = 3'b010,
		SEL_LOW_LIMIT  = 3'b011,
		SEL_CRIT_LIMIT = 3'b100,
		SEL_READING    = 3'b101,
		SEL_MAKER_ID   = 3'b110,
		SEL_PART_ID    = 3'b111
	} select_type;

	localparam logic [7:0] SELECT_RESET = 8'h00;

	// capability word fields
	localparam logic        CAP_EVENT_SUPPORT   = 1'b1;
	localparam logic        CAP_HIGH_ACCURACY   = 1'b1;
	localparam logic        CAP_SIGNED_RANGE    = 1'b1;
	localparam logic [1:0]  CAP_RESOLUTION_CODE = 2'b01;
	localparam logic        CAP_UNUSED_BIT      = 1'b0;
	localparam logic        CAP_TIMEOUT_RANGE   = 1'b0;
	localparam logic        CAP_SHUTDOWN_ALERT  = 1'b0;
	localparam logic [7:0]  CAP_RESERVED_BITS   = 8'h00;
	localparam logic [15:0] CAPABILITY_VALUE    = {CAP_RESERVED_BITS, CAP_SHUTDOWN_ALERT,
		CAP_TIMEOUT_RANGE, CAP_UNUSED_BIT, CAP_RESOLUTION_CODE, CAP_SIGNED_RANGE,
		CAP_HIGH_ACCURACY, CAP_EVENT_SUPPORT};
	localparam int CAP_RES_LSB = 3;
	localparam int CAP_RES_MSB = 4;

	// setup_control bit positions
	localparam int CFG_INT_MODE   = 0;
	localparam int CFG_POLARITY   = 1;
	localparam int CFG_CRIT_ONLY  = 2;
	localparam int CFG_EVENT_EN   = 3;
	localparam int CFG_STATUS     = 4;
	localparam int CFG_CLEAR      = 5;
	localparam int CFG_ALARM_LOCK = 6;
	localparam int CFG_CRIT_LOCK  = 7;
	localparam int CFG_SHUTDOWN   = 8;
	localparam int CFG_HYST_LSB   = 9;
	localparam int CFG_HYST_MSB   = 10;

	localparam logic [15:0] SETUP_RESET = 16'h0000;
	localparam logic [15:0] LIMIT_RESET = 16'h0000;
	localparam logic [15:0] ZERO_WORD   = 16'h0000;

	// hysteresis codes
	localparam logic [1:0] HYST_NONE      = 2'b00;
	localparam logic [1:0] HYST_ONE_HALF  = 2'b01;
	localparam logic [1:0] HYST_THREE     = 2'b10;
	localparam logic [1:0] HYST_SIX       = 2'b11;

	// resolution code decode results
	localparam logic [3:0] RES_BITS_HALF      = 4'h9;
	localparam logic [3:0] RES_BITS_QUARTER   = 4'ha;
	localparam logic [3:0] RES_BITS_EIGHTH    = 4'hb;
	localparam logic [3:0] RES_BITS_SIXTEENTH = 4'hc;
	// step in sixteenths of a degree
	localparam logic [3:0] RES_STEP_HALF      = 4'h8;
	localparam logic [3:0] RES_STEP_QUARTER   = 4'h4;
	localparam logic [3:0] RES_STEP_EIGHTH    = 4'h2;
	localparam logic [3:0] RES_STEP_SIXTEENTH = 4'h1;

	// open-drain event pin always pulls low when enabled
	localparam logic EVENT_PIN_LEVEL = 1'b0;

	// commands from the serial engine
	typedef struct packed {
		logic        select_wr;
		logic [7:0]  select_byte;
		logic        reg_wr;
		logic [15:0] reg_wdata;
	} host_cmd_type;

	// decoded setup fields for the rest of the sensor
	typedef struct packed {
		logic [1:0] hysteresis;
		logic       shutdown;
		logic       crit_lock;
		logic       alarm_lock;
		logic       event_en;
		logic       crit_only;
		logic       polarity;
		logic       int_mode;
	} setup_fields_type;

	localparam setup_fields_type SETUP_FIELDS_RESET = '0;

endpackage

// ### core/thermal_sensor_register_bank.sv
// thermal_sensor_register_bank: pointer-addressed 16-bit register bank of a
// memory-module temperature sensor, with event status and pin drive.
// assumes: a serial engine delivers select and register writes as one-cycle
// strobes in the sys_clk domain; limit comparison happens outside.
//
// Functional notes
// - select latch is 8 bits; top five read zero, low three pick register.
// - selects 0..7 map capability, setup, high, low, critical, reading, maker, part.
// - capability word is a fixed 16-bit read-only value 000Fh.
// - capability bit 0 reads 1: alarm and critical events supported.
// - capability bit 1 reads 1: higher accuracy grade.
// - capability bit 2 reads 1: sub-zero readings carry sign.
// - capability bits 4:3 read 01: 10-bit, quarter-degree readings.
// - resolution code 00..11 decodes to 9..12 bits, half to sixteenth degree.
// - capability bit 5 always reads zero.
// - capability bit 6 reads 0: bus timeout between 10 and 60 ms.
// - event output freezes through shutdown until next sample or comparator update.
// - released-on-shutdown behaviour is not chosen; capability bit 7 reads 0.
// - capability bits 15:8 are reserved and read zero.
// - setup register is 16 bits and resets to zero.
// - select latch resets to zero, picking the capability word.
// - setup bit 5 clears interrupt-mode event, ignored in comparator, reads zero.
// - lock bits 6 and 7 set once, stay until reset, freeze limits.
// - setup bits 10:9 choose hysteresis none, 1.5, 3 or 6 degrees.
`timescale 1ns/1ns
module thermal_sensor_register_bank #(
	// arbitrary neutral identity values
	parameter logic [15:0] MAKER_ID_VALUE = 16'h0a5a,
	parameter logic [15:0] PART_ID_VALUE  = 16'h5a01
) (
	input  wire logic                               sys_clk,
	input  wire logic                               rst,
	input  wire thermal_regs_pkg::host_cmd_type     host_cmd,
	input  wire logic [15:0]                        reading_in,
	input  wire logic                               sample_strobe,
	input  wire logic                               alarm_hit,
	input  wire logic                               critical_hit,
	output logic      [15:0]                        rd_data,
	output logic      [7:0]                         register_select,
	output thermal_regs_pkg::setup_fields_type      setup_fields,
	output logic      [15:0]                        high_limit,
	output logic      [15:0]                        low_limit,
	output logic      [15:0]                        crit_limit,
	output logic      [3:0]                         reading_bits,
	output logic      [3:0]                         reading_step,
	output logic                                    event_pin_out,
	output logic                                    event_pin_oe
);
	import thermal_regs_pkg::*;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	////////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic [15:0] setup_word(input setup_fields_type f,
		input logic status);
		logic [15:0] w;
		w = ZERO_WORD;
		w[CFG_INT_MODE]                = f.int_mode;
		w[CFG_POLARITY]                = f.polarity;
		w[CFG_CRIT_ONLY]               = f.crit_only;
		w[CFG_EVENT_EN]                = f.event_en;
		w[CFG_STATUS]                  = status;
		w[CFG_ALARM_LOCK]              = f.alarm_lock;
		w[CFG_CRIT_LOCK]               = f.crit_lock;
		w[CFG_SHUTDOWN]                = f.shutdown;
		w[CFG_HYST_MSB:CFG_HYST_LSB]   = f.hysteresis;
		return w; // clear bit 5 stays zero on read
	endfunction

	function automatic logic writes_to(input host_cmd_type c, input select_type s,
		input select_type target);
		return c.reg_wr && (s == target);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// select latch

	select_type select_q;
	select_type select_d;

	always_comb begin
		select_d = select_q;
		if (host_cmd.select_wr) begin
			select_d = select_type'(host_cmd.select_byte[SELECT_USED-1:0]);
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			select_q <= select_type'(SELECT_RESET[SELECT_USED-1:0]);
		end else begin
			select_q <= select_d;
		end
	end

	// upper bits are hard zero
	assign register_select = {{(SELECT_WIDTH-SELECT_USED){1'b0}}, select_q};

	////////////////////////////////////////////////////////////////////////////
	// setup and limit registers

	setup_fields_type setup_q;
	setup_fields_type setup_d;
	logic [15:0]      high_q;
	logic [15:0]      high_d;
	logic [15:0]      low_q;
	logic [15:0]      low_d;
	logic [15:0]      crit_q;
	logic [15:0]      crit_d;
	logic             any_lock;
	logic             setup_wr;
	logic [15:0]      wd;

	assign any_lock = setup_q.alarm_lock || setup_q.crit_lock;
	assign setup_wr = writes_to(host_cmd, select_q, SEL_SETUP);
	assign wd       = host_cmd.reg_wdata;

	always_comb begin
		setup_d = setup_q;
		high_d  = high_q;
		low_d   = low_q;
		crit_d  = crit_q;
		if (setup_wr) begin
			// mode, polarity and enable freeze while either lock is set
			if (!any_lock) begin
				setup_d.int_mode = wd[CFG_INT_MODE];
				setup_d.polarity = wd[CFG_POLARITY];
				setup_d.event_en = wd[CFG_EVENT_EN];
			end
			if (!setup_q.alarm_lock) begin
				setup_d.crit_only = wd[CFG_CRIT_ONLY];
			end
			// locks only ever set; reset is the sole way out
			setup_d.alarm_lock = setup_q.alarm_lock || wd[CFG_ALARM_LOCK];
			setup_d.crit_lock  = setup_q.crit_lock || wd[CFG_CRIT_LOCK];
			// shutdown may always be left, entered only when unlocked
			if (!wd[CFG_SHUTDOWN] || !any_lock) begin
				setup_d.shutdown = wd[CFG_SHUTDOWN];
			end
			setup_d.hysteresis = wd[CFG_HYST_MSB:CFG_HYST_LSB];
		end
		if (writes_to(host_cmd, select_q, SEL_HIGH_LIMIT) && !setup_q.alarm_lock) begin
			high_d = wd;
		end
		if (writes_to(host_cmd, select_q, SEL_LOW_LIMIT) && !setup_q.alarm_lock) begin
			low_d = wd;
		end
		if (writes_to(host_cmd, select_q, SEL_CRIT_LIMIT) && !setup_q.crit_lock) begin
			crit_d = wd;
		end
		// writes to capability, reading and identity selects fall through
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			setup_q <= SETUP_FIELDS_RESET;
			high_q  <= LIMIT_RESET;
			low_q   <= LIMIT_RESET;
			crit_q  <= LIMIT_RESET;
		end else begin
			setup_q <= setup_d;
			high_q  <= high_d;
			low_q   <= low_d;
			crit_q  <= crit_d;
		end
	end

	assign setup_fields = setup_q;
	assign high_limit   = high_q;
	assign low_limit    = low_q;
	assign crit_limit   = crit_q;

	////////////////////////////////////////////////////////////////////////////
	// event status and pin

	logic status_q;
	logic status_d;
	logic oe_q;
	logic oe_d;
	logic hit;
	logic clear_req;

	assign hit       = setup_q.crit_only ? critical_hit : (alarm_hit || critical_hit);
	assign clear_req = setup_wr && wd[CFG_CLEAR] && setup_q.int_mode;

	always_comb begin
		status_d = status_q;
		// shutdown freezes the status; the pin holds with it
		if (!setup_q.shutdown) begin
			if (setup_q.int_mode) begin
				if (clear_req) begin
					status_d = 1'b0;
				end
				// a new hit in the clearing cycle still lands
				if (sample_strobe && hit) begin
					status_d = 1'b1;
				end
			end else if (sample_strobe) begin
				status_d = hit;
			end
		end
		// active-low polarity pulls while asserted, active-high while idle
		oe_d = setup_q.event_en && (status_d ^ setup_q.polarity);
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			status_q <= 1'b0;
			oe_q     <= 1'b0;
		end else begin
			status_q <= status_d;
			oe_q     <= oe_d;
		end
	end

	assign event_pin_out = EVENT_PIN_LEVEL;
	assign event_pin_oe  = oe_q;

	////////////////////////////////////////////////////////////////////////////
	// read path

	logic [15:0] rd_q;
	logic [15:0] rd_d;

	always_comb begin
		case (select_q)
			SEL_CAPABILITY: rd_d = CAPABILITY_VALUE;
			SEL_SETUP:      rd_d = setup_word(setup_q, status_q);
			SEL_HIGH_LIMIT: rd_d = high_q;
			SEL_LOW_LIMIT:  rd_d = low_q;
			SEL_CRIT_LIMIT: rd_d = crit_q;
			SEL_READING:    rd_d = reading_in;
			SEL_MAKER_ID:   rd_d = MAKER_ID_VALUE;
			SEL_PART_ID:    rd_d = PART_ID_VALUE;
			default:        rd_d = ZERO_WORD;
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rd_q <= CAPABILITY_VALUE;
		end else begin
			rd_q <= rd_d;
		end
	end

	assign rd_data = rd_q;

	resolution_decoder u_res (
		.res_code (CAPABILITY_VALUE[CAP_RES_MSB:CAP_RES_LSB]),
		.res_bits (reading_bits),
		.res_step (reading_step)
	);

	////////////////////////////////////////////////////////////////////////////
	// checks

	sequence s_int_hit;
		setup_q.int_mode && !setup_q.shutdown && sample_strobe && hit;
	endsequence

	sequence s_held_until_clear;
		status_q ##1 (status_q || $past(clear_req));
	endsequence

	a_select_upper_zero : assert property (
		register_select[SELECT_WIDTH-1:SELECT_USED] == '0)
		else $error("select latch upper bits not zero");
	a_select_hold : assert property (
		!host_cmd.select_wr |=> $stable(select_q))
		else $error("select changed without a select write");
	a_cap_read_value : assert property (
		select_q == SEL_CAPABILITY |=> rd_data == 16'h000f)
		else $error("capability word read wrong");
	a_cap_flag_bits : assert property (
		select_q == SEL_CAPABILITY |=> rd_data[2:0] == 3'b111 && rd_data[15:5] == 11'h000)
		else $error("capability flags wrong");
	a_setup_clear_zero : assert property (
		select_q == SEL_SETUP |=> rd_data[CFG_CLEAR] == 1'b0)
		else $error("clear bit read back nonzero");
	a_alarm_lock_sticky : assert property (
		setup_q.alarm_lock |=> setup_q.alarm_lock)
		else $error("alarm lock bit cleared");
	a_crit_lock_sticky : assert property (
		setup_q.crit_lock |=> setup_q.crit_lock)
		else $error("critical lock bit cleared");
	a_high_frozen : assert property (
		setup_q.alarm_lock && host_cmd.reg_wr && select_q == SEL_HIGH_LIMIT
		|=> $stable(high_q))
		else $error("locked high limit changed");
	a_ro_write_ignored : assert property (
		host_cmd.reg_wr && (select_q >= SEL_READING || select_q == SEL_CAPABILITY)
		|=> $stable(setup_q) && $stable(high_q) && $stable(low_q) && $stable(crit_q))
		else $error("read-only write altered state");
	a_int_event_held : assert property (
		s_int_hit |=> s_held_until_clear)
		else $error("interrupt event lost");
	a_shutdown_freeze : assert property (
		setup_q.shutdown |=> $stable(status_q))
		else $error("event status moved in shutdown");
	a_hyst_store : assert property (
		setup_wr |=> setup_q.hysteresis == $past(wd[CFG_HYST_MSB:CFG_HYST_LSB]))
		else $error("hysteresis not stored");
	a_res_decode : assert property (
		reading_bits == RES_BITS_QUARTER && reading_step == RES_STEP_QUARTER)
		else $error("resolution decode wrong");

endmodule // thermal_sensor_register_bank
